// [core/flash_divider.sv]
// Free-running square wave divider used for the lamp flash rates
`timescale 1ns/1ps
module flash_divider #(
  parameter int unsigned HALF_CYC = 5_000_000,
  parameter int unsigned CNT_W    = 24
) (
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Square wave out
  output logic      wave
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

  logic [CNT_W-1:0] count;
  wire              wrap = (count == LAST);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= '0;
      wave  <= 1'h0;
    end else if (clk_en) begin
      count <= wrap ? '0 : count + CNT_W'(1);
      if (wrap) wave <= ~wave;
    end
  end

endmodule : flash_divider

// [core/status_lamp.sv]
// Status lamp driver with start-up, sync and maintenance-bit visibility
`timescale 1ns/1ps

// Operation
// - U start-up attempt received: lamp flashes at 8 Hz.
// - U interface synchronised: lamp flashes at 1 Hz.
// - Both interfaces active end to end: lamp held low, continuously lit.
// - Alarm bit zero forces 8 Hz flashing even with data flowing.
// - Terminal side toggling H7/H8 keeps lamp on the 1 Hz flash instead of lit.
// - After terminal-side sync loss, about 96 ms pass before resync allowed.
// - U-only bit zero: activate U only, keep terminal side silent.
module status_lamp #(
  parameter int unsigned RESYNC_CYC = lamp_pkg::RESYNC_CYC
) (
  // Clock, reset, enable
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  // Line status and maintenance bits
  input  wire lamp_pkg::line_status_t line_stat,
  input  wire lamp_pkg::maint_bits_t  maint,
  input  wire logic                  st_sync_lost,
  // Power status bits passed upstream
  input  wire logic                  power_status_first_in,
  input  wire logic                  power_status_second_in,
  // Outputs
  output logic                       status_lamp_output_n,
  output logic                       st_enable,
  output logic                       st_resync_allow,
  output logic                       power_status_first,
  output logic                       power_status_second,
  output logic                       power_status_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // Flash sources

  // Both dividers run all the time, so a change of lamp mode picks up
  // the wave wherever it stands; no restart is needed and the flash
  // phase seen on the lamp may therefore start mid half period.
  // Each wave starts low after reset, which shows as a lit lamp.
  logic slow_wave;
  logic fast_wave;

  flash_divider #(
    .HALF_CYC (lamp_pkg::SLOW_HALF_CYC),
    .CNT_W    (lamp_pkg::CNT_W)
  ) u_slow (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wave    (slow_wave)
  );

  flash_divider #(
    .HALF_CYC (lamp_pkg::FAST_HALF_CYC),
    .CNT_W    (lamp_pkg::CNT_W)
  ) u_fast (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wave    (fast_wave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Terminal-side resync hold-off

  logic [lamp_pkg::CNT_W-1:0] hold_cnt;
  wire                        holding = (hold_cnt != '0);

  // Each sync loss reloads the count, so a terminal line that keeps
  // dropping sync within the hold-off stays held; the lamp then rests
  // on the slow flash instead of stuttering between lit and flashing.
  logic [lamp_pkg::CNT_W-1:0] next_hold_cnt;

  always_comb begin
    next_hold_cnt = hold_cnt;
    if (st_sync_lost) begin
      next_hold_cnt = lamp_pkg::CNT_W'(RESYNC_CYC);
    end else if (holding) begin
      next_hold_cnt = hold_cnt - lamp_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_cnt <= '0;
    end else if (clk_en) begin
      hold_cnt <= next_hold_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp mode selection

  // Line status fields under their own names
  wire u_startup = line_stat.u_startup;
  wire u_sync    = line_stat.u_sync;
  wire u_active  = line_stat.u_active;
  wire st_sync   = line_stat.st_sync;
  wire st_active = line_stat.st_active;

  // Maintenance bits, decoded to their special meaning
  wire alarm  = (maint.alarm_bit == lamp_pkg::ALARM_ACTIVE);
  wire u_only = (maint.u_only_bit == lamp_pkg::U_ONLY_ACTIVE);

  // Terminal side counts as up only outside the resync hold-off
  wire st_up  = st_active && st_sync && !holding;

  // Mode conditions, highest priority first. The alarm case sits above
  // the all-up case on purpose: a working link with the alarm bit at
  // zero must still look like a network-side fault on the lamp. A user
  // must know that fast flashing while data flows points at the alarm
  // bit and not at the terminal side. Repeated terminal sync loss keeps
  // the lamp on the slow flash, so it cannot pass for the fast rate.
  wire line_idle   = !u_startup && !u_sync;
  wire u_training  = !u_sync;
  wire alarm_flash = u_active && alarm;
  wire all_up      = u_active && st_up && !u_only;

  lamp_pkg::lamp_mode_t next_mode;

  assign next_mode =
      line_idle   ? lamp_pkg::LAMP_OFF  :
      u_training  ? lamp_pkg::LAMP_FAST :
      alarm_flash ? lamp_pkg::LAMP_FAST :
      all_up      ? lamp_pkg::LAMP_ON   :
                    lamp_pkg::LAMP_SLOW;

  logic next_lamp_n;
  always_comb begin
    unique case (next_mode)
      lamp_pkg::LAMP_OFF:  next_lamp_n = 1'h1;
      lamp_pkg::LAMP_FAST: next_lamp_n = fast_wave;
      lamp_pkg::LAMP_SLOW: next_lamp_n = slow_wave;
      lamp_pkg::LAMP_ON:   next_lamp_n = 1'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Next values of the registered outputs. The terminal side stays
  // silent until the U side is in sync and the U-only bit allows it.
  // The power flag only reports the both-zero case; it does not stop
  // the bits from being passed on, so upstream sees what is supplied.
  wire next_st_enable    = u_sync && !u_only;
  wire next_resync_allow = !holding;
  wire next_power_fault  = !power_status_first_in && !power_status_second_in;

  // Lamp pin, low means lit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_lamp_output_n <= 1'h1;
    end else if (clk_en) begin
      status_lamp_output_n <= next_lamp_n;
    end
  end

  // Terminal side may send its activation signals
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_enable <= 1'h0;
    end else if (clk_en) begin
      st_enable <= next_st_enable;
    end
  end

  // Terminal side may reacquire sync
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_resync_allow <= 1'h0;
    end else if (clk_en) begin
      st_resync_allow <= next_resync_allow;
    end
  end

  // First power status bit passed upstream
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_status_first <= 1'h0;
    end else if (clk_en) begin
      power_status_first <= power_status_first_in;
    end
  end

  // Second power status bit passed upstream
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_status_second <= 1'h0;
    end else if (clk_en) begin
      power_status_second <= power_status_second_in;
    end
  end

  // Both power bits at zero, a value upstream treats as a fault
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_status_fault <= 1'h0;
    end else if (clk_en) begin
      power_status_fault <= next_power_fault;
    end
  end

endmodule : status_lamp

// [include/lamp_pkg.sv]
// Constants and types for the status lamp and activation visibility logic
package lamp_pkg;

  // System clock rate and derived flash dividers
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned SLOW_FLASH_HZ = 1;
  localparam int unsigned FAST_FLASH_HZ = 8;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_HZ);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_HZ);

  // Terminal-side resynchronisation hold-off
  localparam int unsigned RESYNC_MS     = 96;
  localparam int unsigned RESYNC_CYC    = RESYNC_MS * (CLK_HZ / 1000);

  localparam int unsigned CNT_W         = 24;

  // Maintenance bit values that request special behaviour
  localparam logic        ALARM_ACTIVE  = 1'h0;
  localparam logic        U_ONLY_ACTIVE = 1'h0;

  // Lamp display modes
  typedef enum logic [1:0] {
    LAMP_OFF,
    LAMP_FAST,
    LAMP_SLOW,
    LAMP_ON
  } lamp_mode_t;

  // Line status gathered from both interfaces
  typedef struct packed {
    logic u_startup;
    logic u_sync;
    logic u_active;
    logic st_sync;
    logic st_active;
  } line_status_t;

  // Maintenance bits received from the network
  typedef struct packed {
    logic alarm_bit;
    logic u_only_bit;
  } maint_bits_t;

endpackage : lamp_pkg

// [tb/net_model.sv]
// Network-side model driving line status and maintenance bits
`timescale 1ns/1ps
module net_model (
  // Clock and scenario step
  input  wire logic       ref_clk,
  input  wire logic [2:0] step,
  // Toward the block
  output lamp_pkg::line_status_t line_stat,
  output lamp_pkg::maint_bits_t  maint
);
  // Step 1 start-up, 2 synchronised, 3 and up fully active
  always_ff @(posedge ref_clk) begin
    line_stat <= (step == 3'h0) ? 5'h00 : (step == 3'h1) ? 5'h10 :
                 (step == 3'h2) ? 5'h18 : 5'h1F;
    maint     <= {step != 3'h4, step != 3'h5};
  end
endmodule : net_model

// [tb/status_lamp_properties.sv]
// Concurrent checks on the status lamp ports
`timescale 1ns/1ps
module status_lamp_properties #(parameter int unsigned RESYNC_CYC = 20) (
  // Clock, reset and inputs
  input wire logic ref_clk, rst_n, clk_en, st_sync_lost,
  input wire lamp_pkg::line_status_t line_stat,
  input wire lamp_pkg::maint_bits_t maint,
  input wire logic power_status_first_in, power_status_second_in,
  // Outputs
  input wire logic status_lamp_output_n, st_enable, st_resync_allow,
  input wire logic power_status_first, power_status_second, power_status_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_off;
    clk_en && !line_stat.u_startup && !line_stat.u_sync |=> status_lamp_output_n;
  endproperty
  a_off: assert property (p_off) else $error("lamp lit without line start-up");
  property p_on;
    clk_en && line_stat == 5'h1F && maint == 2'h3 && st_resync_allow && !st_sync_lost
      |=> !status_lamp_output_n;
  endproperty
  a_on: assert property (p_on) else $error("lamp not lit with all up");
  property p_uonly;
    clk_en && !maint.u_only_bit |=> !st_enable;
  endproperty
  a_uonly: assert property (p_uonly) else $error("terminal side enabled");
  property p_drop;
    clk_en && st_sync_lost |=> ##1 !st_resync_allow [*8];
  endproperty
  a_drop: assert property (p_drop) else $error("resync allowed too soon");
  property p_rise;
    $rose(st_resync_allow) |-> !$past(st_sync_lost);
  endproperty
  a_rise: assert property (p_rise) else $error("resync allowed at sync loss");
  property p_fault;
    clk_en |=> power_status_fault == (!$past(power_status_first_in)
                                      && !$past(power_status_second_in));
  endproperty
  a_fault: assert property (p_fault) else $error("power fault flag wrong");
  property p_copy;
    clk_en |=> {power_status_first, power_status_second}
               == {$past(power_status_first_in), $past(power_status_second_in)};
  endproperty
  a_copy: assert property (p_copy) else $error("power status copy wrong");
  property p_freeze;
    !clk_en |=> $stable(status_lamp_output_n) && $stable(st_enable);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  c_lost: cover property (clk_en && st_sync_lost);
  c_uonly: cover property (!maint.u_only_bit);
  c_on: cover property (!status_lamp_output_n && st_resync_allow);
endmodule : status_lamp_properties
bind status_lamp status_lamp_properties #(.RESYNC_CYC(RESYNC_CYC)) status_lamp_properties_inst (.*);

// [tb/status_lamp_tb_top.sv]
// Self-checking testbench for the status lamp block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: output differs", $time); end end
module status_lamp_tb_top;
  logic ref_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, st_sync_lost = 1'h0;
  logic power_status_first_in = 1'h1, power_status_second_in = 1'h1;
  logic [2:0] step = 3'h0;
  int err_total = 0, checks_done = 0;
  lamp_pkg::line_status_t line_stat;
  lamp_pkg::maint_bits_t maint;
  logic status_lamp_output_n, st_enable, st_resync_allow;
  logic power_status_first, power_status_second, power_status_fault;
  net_model net_model_inst (.*);
  status_lamp #(.RESYNC_CYC(20)) status_lamp_inst (.*);
  function automatic logic exp_fault(logic a, logic b);
    return !a && !b;
  endfunction : exp_fault
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : tick
  task automatic finish_test;
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin forever #50 ref_clk = ~ref_clk; end
  initial begin #1_000_000; err_total++; finish_test; end
  initial begin
    void'($urandom(95773));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    tick(3);
    `CHK(status_lamp_output_n, 1'h1)
    @(posedge ref_clk);
    step <= 3'h5;
    tick(3);
    `CHK(st_enable, 1'h0)
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      {power_status_first_in, power_status_second_in} <= 2'($urandom);
      tick(2);
      `CHK(power_status_fault, exp_fault(power_status_first_in, power_status_second_in))
      `CHK(power_status_first, power_status_first_in)
      `CHK(power_status_second, power_status_second_in)
    end
    @(posedge ref_clk);
    {power_status_first_in, power_status_second_in} <= 2'h3;
    st_sync_lost <= 1'h1;
    @(posedge ref_clk);
    st_sync_lost <= 1'h0;
    tick(10);
    `CHK(st_resync_allow, 1'h0)
    tick(15);
    `CHK(st_resync_allow, 1'h1)
    @(posedge ref_clk);
    step <= 3'h3;
    tick(3);
    `CHK(status_lamp_output_n, 1'h0)
    `CHK(st_enable, 1'h1)
    @(posedge ref_clk);
    step <= 3'h4;
    tick(3);
    `CHK(status_lamp_output_n, 1'h0)
    `CHK(st_enable, 1'h1)
    @(posedge ref_clk);
    clk_en <= 1'h0;
    step <= 3'h0;
    tick(4);
    `CHK(status_lamp_output_n, 1'h0)
    @(posedge ref_clk);
    clk_en <= 1'h1;
    tick(3);
    `CHK(status_lamp_output_n, 1'h1)
    finish_test;
  end
endmodule : status_lamp_tb_top
